// ### inc/sbs_pkg.sv
package sbs_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLEEP_CYCLES = 2;
  localparam logic [1:0] SLEEP_CNT_MAX = 2'h2;

  // ----------------------------------------------------------------------
  // Burst order strap levels
  // ----------------------------------------------------------------------
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;

  // ----------------------------------------------------------------------
  // Access states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBS_IDLE = 2'b00,
    SBS_READ = 2'b01,
    SBS_WRITE = 2'b10,
    SBS_SLEEP = 2'b11
  } sbs_state_t;

endpackage

// ### verilog/sbs_skid.sv
`timescale 1ns/1ps
`default_nettype none

module sbs_skid #(
  parameter int WIDTH = 36
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------------
  // Two-entry buffer
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  initial begin
    if (WIDTH < 1) $error("sbs_skid WIDTH must be positive");
  end

  // Full and empty follow the occupancy count, so a stalled drain fills it.
  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  // Pointers and occupancy; push and pop may happen in one cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; out_valid guards stale words.
  always_ff @(posedge mclk) begin
    if (push) mem_q[wr_ptr_q] <= in_data;
  end

endmodule

`default_nettype wire

// ### verilog/sbs_port.sv
// Behaviour
// - Every synchronous input is captured in registers on the rising clock.
// - Strap high selects interleaved burst order, low selects linear order.
// - A 2-bit counter holds burst start and generates following addresses.
// - Address and selects are registered every clock; the address loads base_q only when a strobe is taken.
// - Address sampled with strobe low and all selects active; low bits load counter.
// - Byte-lane write selects are active low and need the lane qualifier; here all four selects low at once start no write.
// - Global write low writes every lane, ignoring lane selects and qualifier.
// - Counter advances on each edge where the advance input is low, except in an address cycle or when idle.
// - Selected only when primary low, expand-high high, expand low.
// - Processor strobe is ignored while the primary select is high; here it still blocks the controller strobe.
// - Selects are evaluated only when a new external address loads.
// - Output enable is asynchronous; low drives pins, high floats them.
// - Pins stay undriven in the first clock of a read after deselect.
// - With both strobes low, only the processor strobe is acted on.
// - Controller strobe low captures the presented address.
// - Active-high sleep input gives a low-power state preserving contents.
// - Write data on data and parity pins is captured on the rising clock.
// - Outputs float during write data, first clock after deselect, and deselect.
// - Processor-strobe writes ignore write controls in the address cycle.
// - Entering and leaving sleep each take two clock cycles.
// - Burst counter wraps within its four-address group.
`timescale 1ns/1ps
`default_nettype none

module sbs_port #(
  parameter int ADDR_W = sbs_pkg::ADDR_W,
  parameter int LANES = sbs_pkg::LANES,
  parameter int LANE_W = sbs_pkg::LANE_W,
  parameter int DEPTH = 1024
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic select_primary_n,
  input wire logic select_expand_hi,
  input wire logic select_expand_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic lane_write_qualify_n,
  input wire logic all_lanes_write_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  input wire logic [LANES*LANE_W-1:0] data_in,
  output logic [LANES*LANE_W-1:0] data_out,
  output logic data_oe,
  output logic sleeping,
  output logic wr_ready
);

  localparam int DW = LANES * LANE_W;
  localparam int IDX_W = $clog2(DEPTH);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  initial begin
    if (ADDR_W < sbs_pkg::BURST_W + 1) $error("ADDR_W too small");
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
    if (IDX_W > ADDR_W) $error("DEPTH exceeds address space");
  end

  // ----------------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0] addr_q;
  logic sp_n_q, se_hi_q, se_n_q, cpu_n_q, ctrl_n_q, adv_n_q;
  logic [LANES-1:0] lane_n_q;
  logic qual_n_q, all_n_q;
  logic [DW-1:0] din_q;

  // Every synchronous pin passes through a rising-edge register first.
  always_ff @(posedge mclk) begin
    addr_q <= addr;
    sp_n_q <= select_primary_n;
    se_hi_q <= select_expand_hi;
    se_n_q <= select_expand_n;
    cpu_n_q <= cpu_addr_strobe_n;
    ctrl_n_q <= ctrl_addr_strobe_n;
    adv_n_q <= burst_advance_n;
    lane_n_q <= byte_lane_write_n;
    qual_n_q <= lane_write_qualify_n;
    all_n_q <= all_lanes_write_n;
    din_q <= data_in;
  end

  // ----------------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------------
  // The processor strobe wins over the controller strobe; while the primary
  // select is high it starts nothing itself but still blocks the controller strobe.
  wire selected = !sp_n_q && se_hi_q && !se_n_q;
  wire cpu_take = !cpu_n_q && !sp_n_q;
  wire ctrl_take = !ctrl_n_q && cpu_n_q;
  wire any_take = cpu_take || ctrl_take;
  wire new_addr = any_take && selected;
  wire deselect = any_take && !selected;
  wire lane_wr_any = !qual_n_q && (lane_n_q != '0);
  wire wr_req = !all_n_q || lane_wr_any;

  // Lane enables: global write overrides, else lane selects with qualifier.
  logic [LANES-1:0] lane_en;
  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign lane_en[g] = !all_n_q || (!qual_n_q && !lane_n_q[g]);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Burst counter and state
  // ----------------------------------------------------------------------
  sbs_pkg::sbs_state_t state_q, state_d;
  logic [ADDR_W-1:0] base_q;
  logic [1:0] start_q, cnt_q;
  logic first_q;
  logic was_desel_q;
  logic order_q;
  logic [1:0] sleep_cnt_q;
  logic sleep_q;

  // Linear adds the count, interleaved XORs it; both stay in 2 bits.
  wire [1:0] offset = (order_q == sbs_pkg::ORDER_INTERLEAVED) ?
                      (start_q ^ cnt_q) : (start_q + cnt_q);
  wire [ADDR_W-1:0] cur_addr = {base_q[ADDR_W-1:2], offset};
  wire advance = !adv_n_q && !any_take && (state_q != sbs_pkg::SBS_IDLE);

  // Next access state from the registered strobes.
  always_comb begin
    state_d = state_q;
    if (sleep_q) begin
      state_d = sbs_pkg::SBS_SLEEP;
    end else if (new_addr) begin
      if (ctrl_take && wr_req) begin
        state_d = sbs_pkg::SBS_WRITE;
      end else if (cpu_take) begin
        state_d = sbs_pkg::SBS_WRITE;
      end else begin
        state_d = sbs_pkg::SBS_READ;
      end
    end else if (deselect) begin
      state_d = sbs_pkg::SBS_IDLE;
    end else if (state_q == sbs_pkg::SBS_SLEEP) begin
      state_d = sbs_pkg::SBS_IDLE;
    end
  end

  // Address capture and burst stepping; the strap is sampled each cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= sbs_pkg::SBS_IDLE;
      base_q <= '0;
      start_q <= 2'h0;
      cnt_q <= 2'h0;
      first_q <= 1'b0;
      was_desel_q <= 1'b1;
      order_q <= sbs_pkg::ORDER_INTERLEAVED;
    end else begin
      order_q <= burst_order;
      state_q <= state_d;
      first_q <= new_addr;
      if (new_addr) begin
        base_q <= addr_q;
        start_q <= addr_q[1:0];
        cnt_q <= 2'h0;
      end else if (advance) begin
        cnt_q <= cnt_q + 2'h1;
      end
      was_desel_q <= (state_q == sbs_pkg::SBS_IDLE) || (state_q == sbs_pkg::SBS_SLEEP);
    end
  end

  // ----------------------------------------------------------------------
  // Sleep entry and exit, two cycles each
  // ----------------------------------------------------------------------
  // The sleep pin is taken as synchronous here; a pending access is dropped.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sleep_cnt_q <= 2'h0;
      sleep_q <= 1'b0;
    end else if (sleep_request != sleep_q) begin
      if (sleep_cnt_q == sbs_pkg::SLEEP_CNT_MAX - 2'h1) begin
        sleep_q <= sleep_request;
        sleep_cnt_q <= 2'h0;
      end else begin
        sleep_cnt_q <= sleep_cnt_q + 2'h1;
      end
    end else begin
      sleep_cnt_q <= 2'h0;
    end
  end
  assign sleeping = sleep_q;

  // ----------------------------------------------------------------------
  // Write path through the two-entry buffer
  // ----------------------------------------------------------------------
  // A processor-strobe write commits at the cycle after its address cycle;
  // controller writes commit in the address cycle with captured data.
  wire cpu_wr_phase = (state_q == sbs_pkg::SBS_WRITE) && !first_q && !any_take;
  wire ctrl_wr_now = new_addr && ctrl_take && wr_req;
  wire wr_fire = !sleep_q && ((cpu_wr_phase && wr_req) || ctrl_wr_now ||
                 (state_q == sbs_pkg::SBS_WRITE) && first_q && !any_take && wr_req);
  wire [ADDR_W-1:0] wr_addr = ctrl_wr_now ? addr_q : cur_addr;
  wire [LANES-1:0] wr_lanes = lane_en;
  localparam int PKT_W = IDX_W + LANES + DW;
  logic buf_valid;
  logic [PKT_W-1:0] buf_pkt;
  logic buf_in_ready;

  sbs_skid #(
    .WIDTH(PKT_W)
  ) u_skid (
    .mclk(mclk),
    .rst(rst),
    .in_valid(wr_fire),
    .in_ready(buf_in_ready),
    .in_data({wr_addr[IDX_W-1:0], wr_lanes, din_q}),
    .out_valid(buf_valid),
    .out_ready(!sleep_q),
    .out_data(buf_pkt)
  );
  assign wr_ready = buf_in_ready;

  // ----------------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------------
  wire [IDX_W-1:0] mem_wa = buf_pkt[PKT_W-1 -: IDX_W];
  wire [IDX_W-1:0] mem_ra = cur_addr[IDX_W-1:0];
  wire [LANES-1:0] mem_we = buf_pkt[DW +: LANES];
  wire [DW-1:0] mem_wd = buf_pkt[DW-1:0];
  wire [DW-1:0] mem_rd;

  // Lane-masked write; contents are held through sleep.
  // Each lane keeps its own array so that one process alone writes it.
  generate
    for (genvar l = 0; l < LANES; l++) begin : g_mem
      logic [LANE_W-1:0] lane_q [DEPTH];
      assign mem_rd[l*LANE_W +: LANE_W] = lane_q[mem_ra];
      always_ff @(posedge mclk) begin
        if (buf_valid && !sleep_q && mem_we[l]) begin
          lane_q[mem_wa] <= mem_wd[l*LANE_W +: LANE_W];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read data and output drive
  // ----------------------------------------------------------------------
  logic [DW-1:0] rd_q;
  logic rd_live_q;

  // Read data is registered; the drive window excludes write, deselect and
  // the first read clock after a deselected state.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_q <= '0;
      rd_live_q <= 1'b0;
    end else begin
      rd_q <= mem_rd;
      // A decoded deselect drops the drive at once, not one state later.
      rd_live_q <= (state_q == sbs_pkg::SBS_READ) && !(first_q && was_desel_q) &&
                   !sleep_q && !deselect;
    end
  end
  assign data_out = rd_q;
  assign data_oe = rd_live_q && !output_enable_n;

endmodule

`default_nettype wire

// ### tb/sbs_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module sbs_port_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic select_primary_n,
  input wire logic select_expand_hi,
  input wire logic select_expand_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic lane_write_qualify_n,
  input wire logic all_lanes_write_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic data_oe,
  input wire logic sleeping
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Deselect, read start and quiet cycles as the host presents them.
  sequence s_desel; !ctrl_addr_strobe_n && cpu_addr_strobe_n && !select_expand_hi; endsequence
  sequence s_rd;
    !ctrl_addr_strobe_n && cpu_addr_strobe_n && !select_primary_n && select_expand_hi &&
      !select_expand_n && all_lanes_write_n && lane_write_qualify_n && !output_enable_n;
  endsequence
  sequence s_quiet;
    cpu_addr_strobe_n && ctrl_addr_strobe_n && burst_advance_n && !output_enable_n;
  endsequence
  property p_oe_async; output_enable_n |-> !data_oe; endproperty
  property p_mask; s_desel ##1 s_rd |=> !data_oe [*3]; endproperty
  property p_rd_lat; s_desel ##1 s_rd ##1 s_quiet [*3] |=> data_oe; endproperty
  property p_desel; s_desel |=> ##1 !data_oe; endproperty
  property p_wr_float;
    !all_lanes_write_n && cpu_addr_strobe_n && ctrl_addr_strobe_n |=> ##1 !data_oe;
  endproperty
  property p_cpu_ign; s_desel ##1 (!cpu_addr_strobe_n && select_primary_n) |=> !data_oe [*3];
  endproperty
  property p_slp_in; sleep_request [*5] |-> sleeping; endproperty
  property p_slp_out; !sleep_request [*5] |-> !sleeping; endproperty
  property p_slp_slow; $rose(sleep_request) |=> !sleeping; endproperty
  a_oe_async: assert property (p_oe_async) else $error("pads driven, enable off");
  a_mask: assert property (p_mask) else $error("first read clock not masked");
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  a_desel: assert property (p_desel) else $error("pads driven, deselected");
  a_wr_float: assert property (p_wr_float) else $error("pads driven in write");
  a_cpu_ign: assert property (p_cpu_ign) else $error("cpu strobe not ignored");
  a_slp_in: assert property (p_slp_in) else $error("sleep not entered");
  a_slp_out: assert property (p_slp_out) else $error("sleep not left");
  a_slp_slow: assert property (p_slp_slow) else $error("sleep entered at once");
endmodule
`default_nettype wire

// ### tb/sbs_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Host side of the memory bus
// ----------------------------------------------------------------------
module sbs_host (
  input wire logic mclk,
  input wire logic data_oe,
  input wire logic [35:0] data_out,
  output logic [19:0] addr,
  output logic select_primary_n,
  output logic select_expand_hi,
  output logic select_expand_n,
  output logic cpu_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_advance_n,
  output logic [3:0] byte_lane_write_n,
  output logic lane_write_qualify_n,
  output logic all_lanes_write_n,
  output logic output_enable_n,
  output logic [35:0] data_in
);
  logic [35:0] drv_q = 36'h0;
  logic drv_en = 1'b0;
  // A released bus shows the inverse of the last word, so stale data never passes.
  assign data_in = data_oe ? data_out : (drv_en ? drv_q : ~drv_q);
  // Bits of k, active high: expand deselect, cpu, ctrl, advance, global write,
  // lane qualifier, output enable, primary deselect.
  function automatic void put(input logic [7:0] k, input logic [19:0] a,
                              input logic [3:0] w, input logic [35:0] d);
    addr = a;
    select_expand_hi = !k[7];
    select_primary_n = k[0];
    select_expand_n = 1'b0;
    cpu_addr_strobe_n = !k[6];
    ctrl_addr_strobe_n = !k[5];
    burst_advance_n = !k[4];
    all_lanes_write_n = !k[3];
    lane_write_qualify_n = !k[2];
    byte_lane_write_n = ~w;
    output_enable_n = !k[1];
    drv_en = k[3] | k[2];
    if (drv_en) begin
      drv_q = d;
    end
  endfunction
  // Requests change only just after a falling edge.
  task automatic step(input logic [7:0] k, input logic [19:0] a, input logic [3:0] w,
                      input logic [35:0] d);
    @(negedge mclk);
    put(k, a, w, d);
  endtask
  initial begin
    put(8'h00, 20'h00000, 4'h0, 36'h0);
  end
endmodule
`default_nettype wire

// ### tb/sync_burst_sram_port_test.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench for the burst memory port
// ----------------------------------------------------------------------
module sync_burst_sram_port_test;
  localparam logic [7:0] K_DES = 8'h80, K_CPU = 8'h40, K_CTL = 8'h20, K_ADV = 8'h10;
  localparam logic [7:0] K_GW = 8'h08, K_BWE = 8'h04, K_OE = 8'h02, K_PRI = 8'h01;
  localparam logic [19:0] BASE = 20'h00010;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sleep_request = 1'b0;
  logic burst_order = 1'b0;
  logic [35:0] mem [4];
  logic [35:0] got [4];
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  wire [19:0] addr;
  wire [3:0] byte_lane_write_n;
  wire [35:0] data_in, data_out;
  wire select_primary_n, select_expand_hi, select_expand_n, cpu_addr_strobe_n;
  wire ctrl_addr_strobe_n, burst_advance_n, lane_write_qualify_n, all_lanes_write_n;
  wire output_enable_n, data_oe, sleeping, wr_ready;
  sbs_port dut (.mclk, .rst, .addr, .select_primary_n, .select_expand_hi, .select_expand_n,
    .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n, .byte_lane_write_n,
    .lane_write_qualify_n, .all_lanes_write_n, .output_enable_n, .sleep_request,
    .burst_order, .data_in, .data_out, .data_oe, .sleeping, .wr_ready);
  sbs_host host (.mclk, .data_oe, .data_out, .addr, .select_primary_n, .select_expand_hi,
    .select_expand_n, .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
    .byte_lane_write_n, .lane_write_qualify_n, .all_lanes_write_n, .output_enable_n,
    .data_in);
  task automatic chk(input logic [35:0] seen, input logic [35:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Cpu address cycle, then the write controls one clock later.
  task automatic wr(input logic [19:0] a, input logic [7:0] k0, input logic [7:0] k1,
                    input logic [3:0] w, input logic [35:0] d);
    chk({35'h0, wr_ready}, 36'h1);
    host.step(K_CPU | k0, a, w, d);
    host.step(k1, a, w, d);
    host.step(8'h00, a, 4'h0, 36'h0);
  endtask
  // Read from deselect; one advance per word after the first, waiting for each word to appear.
  task automatic rd(input logic [19:0] a, input int n);
    int i;
    int t;
    host.step(K_DES | K_CTL, a, 4'h0, 36'h0);
    host.step(K_CTL | K_OE, a, 4'h0, 36'h0);
    for (i = 0; i < n; i++) begin
      host.step(i > 0 ? K_OE | K_ADV : K_OE, a, 4'h0, 36'h0);
      host.step(K_OE, a, 4'h0, 36'h0);
      for (t = 0; t < 6 && (data_oe !== 1'b1 || (i > 0 && data_out === got[i-1])); t++) begin
        @(posedge mclk);
        #1;
      end
      got[i] = data_out;
    end
  endtask
  task automatic t_fill;
    for (int i = 0; i < 4; i++) begin
      mem[i] = 36'h9_8765_4320 + 36'(i * 5);
      wr(BASE + 20'(i), 8'h00, i == 2 ? K_GW | K_BWE : K_GW, 4'h0, mem[i]);
    end
    rd(BASE, 1);
    chk(got[0], mem[0]);
  endtask
  // Both orders from odd starts, so every burst has to wrap inside its group.
  task automatic t_bursts;
    for (int o = 0; o < 2; o++) begin
      for (int s = 1; s < 4; s += 2) begin
        @(negedge mclk);
        burst_order = o[0];
        rd(BASE + 20'(s), 4);
        for (int n = 0; n < 4; n++) begin
          chk(got[n], mem[o == 1 ? (s ^ n) : ((s + n) % 4)]);
        end
      end
    end
  endtask
  task automatic t_lanes;
    logic [35:0] d;
    logic [35:0] m;
    d = 36'hF_0F0F_0F0F;
    m = {9'h000, 9'h1FF, 9'h000, 9'h1FF};
    wr(BASE, 8'h00, K_BWE, 4'h5, d);
    mem[0] = (d & m) | (mem[0] & ~m);
    wr(BASE + 20'h1, 8'h00, 8'h00, 4'hF, d);
    wr(BASE + 20'h2, K_GW, 8'h00, 4'h0, d);
    // Controller-strobe write: controls and data ride the address cycle.
    host.step(K_CTL | K_GW, BASE + 20'h3, 4'h0, ~d);
    host.step(8'h00, BASE, 4'h0, 36'h0);
    mem[3] = ~d;
    rd(BASE, 4);
    chk(got[0], mem[0]);
    chk(got[1], mem[1]);
    chk(got[2], mem[2]);
    chk(got[3], mem[3]);
  endtask
  // A cpu strobe with the primary select high starts nothing, ctrl strobe or not.
  task automatic t_ignored;
    for (int c = 0; c < 2; c++) begin
      host.step(K_DES | K_CTL, BASE, 4'h0, 36'h0);
      host.step(K_CPU | K_PRI | K_OE | (c == 1 ? K_CTL : 8'h00), BASE, 4'h0, 36'h0);
      for (int i = 0; i < 4; i++) begin
        host.step(K_OE, BASE, 4'h0, 36'h0);
        chk({35'h0, data_oe}, 36'h0);
      end
    end
  endtask
  task automatic t_sleep;
    @(negedge mclk);
    sleep_request = 1'b1;
    @(negedge mclk);
    chk({35'h0, sleeping}, 36'h0);
    repeat (5) @(negedge mclk);
    chk({35'h0, sleeping}, 36'h1);
    sleep_request = 1'b0;
    repeat (6) @(negedge mclk);
    chk({35'h0, sleeping}, 36'h0);
    rd(BASE + 20'h3, 1);
    chk(got[0], mem[3]);
  endtask
  initial begin
    forever #20 mclk = ~mclk;
  end
  // A hang ends the run as a failure.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    chk({33'h0, data_oe, sleeping, wr_ready}, 36'h1);
    t_fill();
    t_bursts();
    t_lanes();
    t_ignored();
    t_sleep();
    tally_and_finish();
  end
endmodule
bind sbs_port sbs_port_asserts chk_port (.mclk, .rst, .select_primary_n, .select_expand_hi,
  .select_expand_n, .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
  .lane_write_qualify_n, .all_lanes_write_n, .output_enable_n, .sleep_request, .data_oe,
  .sleeping);
`default_nettype wire
